/* logic/iet_dev.sv */
// Purpose: interrupt IN endpoint with source fifo and replay buffer
// Assumes: host keeps its own side of the link
// Notes:   ack mode caps packets at the replay buffer size
//
// Notes on behaviour
// - full-speed interval reported as 1..255 ms
// - low-speed interval reported as 10..255 ms
// - high-speed interval 1..16, period 2^(n-1)x125us
// - host gap never exceeds desired period
// - host polls only with request pending
// - high-speed up to 3072 bytes, 1024 per transaction
// - high-bandwidth endpoint reports interval one
// - no data pending: answer with NAK
// - send data only when really pending
// - zero-length packet is a valid transfer
// - toggle on ack, or on every packet
// - host always applies full handshake rules
// - always-toggle mode ignores host handshakes
// - host retires all requests on halt
// - halt clear resets toggle to DATA0
// - host retries transactions hit by errors
// - host budgets with fixed high-speed overheads
// - transfer ends on count, short or empty packet
// - default setting payload at most 64 bytes
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////
module iet_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clock_i,     // clock
  input  wire logic         rst_i,       // async reset
  input  wire logic         in_valid_i,  // push request
  output logic              in_ready_o,  // room left
  input  wire logic [W-1:0] in_data_i,   // push word
  output logic              out_valid_o, // word present
  input  wire logic         out_ready_i, // pop request
  output logic [W-1:0]      out_data_o   // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0]   cnt_reg;
  logic [AW:0]   cnt_next;
  logic          rdy_reg;
  wire           push = in_valid_i & rdy_reg;
  wire           pop  = out_ready_i & out_valid_o;

  assign cnt_next    = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign in_ready_o  = rdy_reg;
  assign out_valid_o = cnt_reg != '0;
  assign out_data_o  = mem[rp_reg];

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wp_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
      rdy_reg <= 1'b0;
    end else begin
      wp_reg  <= push ? wp_reg + 1'b1 : wp_reg;
      rp_reg  <= pop ? rp_reg + 1'b1 : rp_reg;
      cnt_reg <= cnt_next;
      rdy_reg <= cnt_next != (AW+1)'(DEPTH);
    end
  end
endmodule : iet_fifo

////////////////////////////////////////////////////////////////
module iet_dev #(
  parameter iet_pkg::iet_speed_t SPEED        = iet_pkg::IET_FULL,
  parameter logic [7:0]          INTERVAL_REQ = 8'h01,
  parameter logic [11:0]         MPS_REQ      = 12'h008,
  parameter bit                  TOG_ALWAYS   = 1'b0
) (
  input  wire logic  clock_i,       // clock
  input  wire logic  rst_i,         // async reset
  iet_if.dev         lnk,           // link to host
  input  wire logic  wr_valid_i,    // data byte offered
  input  wire logic [7:0] wr_data_i, // data byte
  input  wire logic  wr_last_i,     // byte ends a packet
  output logic       wr_ready_o,    // fifo has room
  input  wire logic  zlp_req_i,     // queue empty packet
  input  wire logic  halt_i,        // stall the endpoint
  input  wire logic  alt_setting_i, // alternate setting
  output logic [7:0] interval_o,    // reported interval
  output logic [11:0] max_pkt_o,    // reported payload size
  output logic       hi_bw_o,       // high-bandwidth
  output logic       toggle_o,      // next data pid
  output logic       halted_o,      // endpoint halted
  output logic       sent_o         // new packet sent
);
  import iet_pkg::*;

  typedef enum logic [2:0] {
    D_IDLE   = 3'b001,
    D_SEND   = 3'b010,
    D_REPLAY = 3'b100
  } iet_dstate_t;

  iet_dstate_t state_reg, state_next;
  logic [7:0]  interval_reg;
  logic [11:0] mps_reg;
  logic        hi_bw_reg;
  logic [11:0] txn_max_reg;
  logic        toggle_reg, toggle_next;
  logic        unacked_reg, unacked_next;
  logic        halted_reg;
  logic        zlp_pend_reg;
  logic [11:0] idx_reg, idx_next;
  logic [11:0] buf_len_reg, buf_len_next;
  logic        nak_reg, stall_reg, dv_reg, dend_reg, dpid_reg, sent_reg;
  logic [7:0]  dbyte_reg;
  logic [7:0]  pkt_buf [REPLAY_BYTES];
  logic        f_valid;
  logic [8:0]  f_data;
  logic        fifo_pop;

  ////////////////////////////////////////////////////////////////
  // descriptor values
  wire        is_hs = SPEED == IET_HIGH;
  wire        is_ls = SPEED == IET_LOW;
  wire [11:0] big_w = TOG_ALWAYS ? HS_MAX_UFRAME : REPLAY_BYTES;
  wire [11:0] cap_w = is_ls ? LS_MAX_PKT :
                      !is_hs ? FS_MAX_PKT :
                      alt_setting_i ? big_w : DEF_MAX_PKT;
  wire [11:0] mps_w = (MPS_REQ > cap_w) ? cap_w : MPS_REQ;
  wire        hib_w = is_hs && (mps_w > HS_MAX_TXN);
  wire [7:0]  hs_int_w = (INTERVAL_REQ < HS_INT_MIN) ? HS_INT_MIN :
                         (INTERVAL_REQ > HS_INT_MAX) ? HS_INT_MAX : INTERVAL_REQ;
  wire [7:0]  ls_int_w = (INTERVAL_REQ < LS_INT_MIN) ? LS_INT_MIN : INTERVAL_REQ;
  wire [7:0]  fs_int_w = (INTERVAL_REQ < FS_INT_MIN) ? FS_INT_MIN : INTERVAL_REQ;
  wire [7:0]  int_w = is_hs ? (hib_w ? HS_INT_MIN : hs_int_w) :
                      is_ls ? ls_int_w : fs_int_w;
  wire [11:0] txn_w = hib_w ? HS_MAX_TXN : mps_w;

  ////////////////////////////////////////////////////////////////
  // source fifo
  iet_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .in_valid_i  (wr_valid_i),
    .in_ready_o  (wr_ready_o),
    .in_data_i   ({wr_last_i, wr_data_i}),
    .out_valid_o (f_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (f_data)
  );

  ////////////////////////////////////////////////////////////////
  // poll decode
  wire idle     = state_reg == D_IDLE;
  wire poll     = idle & lnk.tok_in;
  wire live     = poll & ~halted_reg;
  wire must_rep = ~TOG_ALWAYS & unacked_reg;
  wire st_rep   = live & must_rep & (buf_len_reg != '0);
  wire zl_rep   = live & must_rep & (buf_len_reg == '0);
  wire st_send  = live & ~must_rep & f_valid;
  wire st_zlp   = live & ~must_rep & ~f_valid & zlp_pend_reg;
  wire nak_w    = live & ~must_rep & ~f_valid & ~zlp_pend_reg;
  wire stall_w  = poll & halted_reg;
  assign fifo_pop = (state_reg == D_SEND) & f_valid;
  wire idx_end  = (idx_reg + 12'h001) == txn_max_reg;
  wire send_end = fifo_pop & (f_data[8] | idx_end);
  wire rep_on   = state_reg == D_REPLAY;
  wire rep_end  = rep_on & ((idx_reg + 12'h001) == buf_len_reg);
  wire new_done = send_end | st_zlp;
  wire any_end  = new_done | rep_end | zl_rep;
  wire any_st   = st_rep | zl_rep | st_send | st_zlp;
  wire ack_w    = idle & lnk.hs_ack & unacked_reg & ~TOG_ALWAYS;

  ////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    state_next   = state_reg;
    toggle_next  = toggle_reg;
    unacked_next = unacked_reg;
    idx_next     = idx_reg;
    buf_len_next = buf_len_reg;
    if (st_send) begin
      state_next = D_SEND;
    end else if (st_rep) begin
      state_next = D_REPLAY;
    end else if (send_end | rep_end) begin
      state_next = D_IDLE;
    end
    if (st_send | st_rep) begin
      idx_next = '0;
    end else if (fifo_pop | rep_on) begin
      idx_next = idx_reg + 12'h001;
    end
    if (send_end) begin
      buf_len_next = idx_reg + 12'h001;
    end else if (st_zlp) begin
      buf_len_next = '0;
    end
    if (lnk.clr_halt) begin
      toggle_next  = PID_DATA0;
      unacked_next = 1'b0;
    end else if (TOG_ALWAYS & new_done) begin
      toggle_next  = ~toggle_reg;
    end else if (~TOG_ALWAYS & new_done) begin
      unacked_next = 1'b1;
    end else if (ack_w) begin
      toggle_next  = ~toggle_reg;
      unacked_next = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // replay storage
  always_ff @(posedge clock_i) begin
    if (fifo_pop) begin
      pkt_buf[idx_reg[5:0]] <= f_data[7:0];
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg    <= D_IDLE;
      toggle_reg   <= PID_DATA0;
      unacked_reg  <= 1'b0;
      idx_reg      <= '0;
      buf_len_reg  <= '0;
      halted_reg   <= 1'b0;
      zlp_pend_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      toggle_reg   <= toggle_next;
      unacked_reg  <= unacked_next;
      idx_reg      <= idx_next;
      buf_len_reg  <= buf_len_next;
      halted_reg   <= halt_i | (halted_reg & ~lnk.clr_halt);
      zlp_pend_reg <= zlp_req_i | (zlp_pend_reg & ~st_zlp);
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      nak_reg   <= 1'b0;
      stall_reg <= 1'b0;
      dv_reg    <= 1'b0;
      dend_reg  <= 1'b0;
      dpid_reg  <= PID_DATA0;
      dbyte_reg <= '0;
      sent_reg  <= 1'b0;
    end else begin
      nak_reg   <= nak_w;
      stall_reg <= stall_w;
      dv_reg    <= fifo_pop | rep_on;
      dend_reg  <= any_end;
      dpid_reg  <= any_st ? toggle_reg : dpid_reg;
      dbyte_reg <= fifo_pop ? f_data[7:0] : pkt_buf[idx_reg[5:0]];
      sent_reg  <= new_done;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      interval_reg <= '0;
      mps_reg      <= '0;
      hi_bw_reg    <= 1'b0;
      txn_max_reg  <= '0;
    end else begin
      interval_reg <= int_w;
      mps_reg      <= mps_w;
      hi_bw_reg    <= hib_w;
      txn_max_reg  <= txn_w;
    end
  end

  assign lnk.nak       = nak_reg;
  assign lnk.stall     = stall_reg;
  assign lnk.dat_valid = dv_reg;
  assign lnk.dat_end   = dend_reg;
  assign lnk.dat_pid   = dpid_reg;
  assign lnk.dat_byte  = dbyte_reg;
  assign interval_o    = interval_reg;
  assign max_pkt_o     = mps_reg;
  assign hi_bw_o       = hi_bw_reg;
  assign toggle_o      = toggle_reg;
  assign halted_o      = halted_reg;
  assign sent_o        = sent_reg;
endmodule : iet_dev

/* logic/iet_host.sv */
// Purpose: host end polling one interrupt IN endpoint
// Assumes: descriptor values taken from the endpoint
// Notes:   queued requests share the latest length
`timescale 1ns/1ps
module iet_host #(
  parameter int FRAME_CYC = iet_pkg::FRAME_CYC_DEF
) (
  input  wire logic        clock_i,      // clock
  input  wire logic        rst_i,        // async reset
  iet_if.host              lnk,          // link to endpoint
  input  wire logic        req_i,        // new transfer request
  input  wire logic [15:0] req_len_i,    // expected bytes
  input  wire logic [1:0]  speed_i,      // endpoint speed
  input  wire logic [7:0]  interval_i,   // endpoint interval
  input  wire logic [11:0] mps_i,        // endpoint payload size
  input  wire logic        clear_halt_i, // clear halt
  output logic             rx_valid_o,   // new byte
  output logic [7:0]       rx_data_o,    // byte value
  output logic             done_o,       // transfer complete
  output logic             retired_o,    // requests retired
  output logic             halted_o,     // pipe halted
  output logic [31:0]      budget_o,     // bits per slot
  output logic             over_o        // budget exceeded
);
  import iet_pkg::*;

  typedef enum logic [1:0] {
    H_IDLE = 2'b01,
    H_WAIT = 2'b10
  } iet_hstate_t;

  iet_hstate_t state_reg;
  logic [31:0] timer_reg;
  logic [1:0]  credit_reg, err_reg;
  logic [3:0]  pend_reg;
  logic [15:0] len_reg, moved_reg;
  logic [11:0] pkt_reg;
  logic [4:0]  wait_reg;
  logic        exp_reg, halted_reg, tok_reg, ack_reg, clr_reg;
  logic        rxv_reg, done_reg, ret_reg, over_reg;
  logic [7:0]  rxd_reg;
  logic [31:0] bud_reg;

  wire        is_hs   = speed_i == IET_HIGH;
  wire [7:0]  hs_int  = (interval_i < HS_INT_MIN) ? HS_INT_MIN :
                        (interval_i > HS_INT_MAX) ? HS_INT_MAX : interval_i;
  wire [7:0]  fs_int  = (interval_i == '0) ? FS_INT_MIN : interval_i;
  wire [31:0] period  = is_hs ? (32'(UFRAME_CYC) << (hs_int - 8'h01)) :
                                (32'(fs_int) * 32'(FRAME_CYC));
  wire        tick    = timer_reg >= (period - 32'h1);
  wire [1:0]  lim     = !is_hs ? 2'h1 : (mps_i > HS_TWO_TXN) ? 2'h3 :
                        (mps_i > HS_MAX_TXN) ? 2'h2 : 2'h1;
  wire [11:0] txn_max = (lim != 2'h1) ? HS_MAX_TXN : mps_i;
  wire [31:0] bud_w   = (32'(HS_TXN_OVH_BITS) + 32'(txn_max) * 32'h8) * 32'(lim);
  wire        waiting = state_reg == H_WAIT;
  wire        poll    = ~waiting & (credit_reg != '0) & (pend_reg != '0) & ~halted_reg;
  wire        pid_ok  = lnk.dat_pid == exp_reg;
  wire        byte_in = waiting & lnk.dat_valid;
  wire        end_in  = waiting & lnk.dat_end;
  wire [11:0] pkt_len = pkt_reg + {11'h0, lnk.dat_valid};
  wire [15:0] total   = moved_reg + {4'h0, pkt_len};
  wire        finish  = end_in & pid_ok & ((total >= len_reg) | (pkt_len < txn_max));
  wire        tmo     = waiting & ~lnk.dat_valid & ~lnk.dat_end & (wait_reg == 5'(RESP_TO_CYC - 1));
  wire        to_halt = (waiting & lnk.stall) | (tmo & (err_reg == 2'(ERR_LIMIT - 1)));
  wire        req_ok  = req_i & ~halted_reg & ~to_halt & (pend_reg != 4'hf);
  wire        resp    = waiting & (lnk.nak | lnk.stall | lnk.dat_end);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= H_IDLE;
      timer_reg <= '0;
      credit_reg <= '0;
      wait_reg  <= '0;
      pkt_reg   <= '0;
    end else begin
      timer_reg  <= tick ? '0 : timer_reg + 32'h1;
      credit_reg <= tick ? ((pend_reg != '0) ? lim : 2'h0) :
                    poll ? credit_reg - 2'h1 : credit_reg;
      state_reg  <= poll ? H_WAIT : (resp | tmo) ? H_IDLE : state_reg;
      wait_reg   <= (poll | byte_in) ? '0 : wait_reg + 5'h01;
      pkt_reg    <= poll ? '0 : byte_in ? pkt_reg + 12'h001 : pkt_reg;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pend_reg   <= '0;
      len_reg    <= '0;
      moved_reg  <= '0;
      exp_reg    <= PID_DATA0;
      err_reg    <= '0;
      halted_reg <= 1'b0;
    end else begin
      len_reg    <= req_i ? req_len_i : len_reg;
      pend_reg   <= to_halt ? '0 : pend_reg + {3'h0, req_ok} - {3'h0, finish};
      moved_reg  <= (finish | to_halt) ? '0 : (end_in & pid_ok) ? total : moved_reg;
      exp_reg    <= clear_halt_i ? PID_DATA0 : (end_in & pid_ok) ? ~exp_reg : exp_reg;
      err_reg    <= (clear_halt_i | end_in | lnk.nak) ? '0 : tmo ? err_reg + 2'h1 : err_reg;
      halted_reg <= to_halt | (halted_reg & ~clear_halt_i);
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      tok_reg  <= 1'b0;
      ack_reg  <= 1'b0;
      clr_reg  <= 1'b0;
      rxv_reg  <= 1'b0;
      rxd_reg  <= '0;
      done_reg <= 1'b0;
      ret_reg  <= 1'b0;
      bud_reg  <= '0;
      over_reg <= 1'b0;
    end else begin
      tok_reg  <= poll;
      ack_reg  <= end_in;
      clr_reg  <= clear_halt_i;
      rxv_reg  <= byte_in & pid_ok;
      rxd_reg  <= lnk.dat_byte;
      done_reg <= finish;
      ret_reg  <= to_halt | (req_i & halted_reg);
      bud_reg  <= bud_w;
      over_reg <= is_hs & (bud_w > 32'(HS_BUDGET_BITS));
    end
  end

  assign lnk.tok_in   = tok_reg;
  assign lnk.hs_ack   = ack_reg;
  assign lnk.clr_halt = clr_reg;
  assign rx_valid_o   = rxv_reg;
  assign rx_data_o    = rxd_reg;
  assign done_o       = done_reg;
  assign retired_o    = ret_reg;
  assign halted_o     = halted_reg;
  assign budget_o     = bud_reg;
  assign over_o       = over_reg;
endmodule : iet_host

/* logic/iet_if.sv */
// Purpose: transaction-level link between host and endpoint
// Assumes: both ends on the same clock
// Notes:   all signals are one-cycle pulses except dat_valid, dat_pid and dat_byte
`timescale 1ns/1ps
interface iet_if;
  logic       tok_in;
  logic       hs_ack;
  logic       clr_halt;
  logic       nak;
  logic       stall;
  logic       dat_valid;
  logic       dat_end;
  logic       dat_pid;
  logic [7:0] dat_byte;

  modport host (output tok_in, hs_ack, clr_halt,
                input  nak, stall, dat_valid, dat_end, dat_pid, dat_byte);
  modport dev  (input  tok_in, hs_ack, clr_halt,
                output nak, stall, dat_valid, dat_end, dat_pid, dat_byte);
endinterface : iet_if

/* logic/iet_pkg.sv */
// Purpose: shared constants for the interrupt endpoint link
// Assumes: one 10 MHz clock for both ends
// Notes:   sizes in bytes, times in us, counts in cycles
package iet_pkg;
  localparam int CLK_MHZ         = 10;
  localparam int FRAME_US        = 1000;
  localparam int UFRAME_US       = 125;
  localparam int FRAME_CYC_DEF   = FRAME_US * CLK_MHZ;
  localparam int UFRAME_CYC      = UFRAME_US * CLK_MHZ;
  localparam int RESP_TO_CYC     = 16;
  localparam int ERR_LIMIT       = 3;

  typedef enum logic [1:0] {
    IET_LOW  = 2'h0,
    IET_FULL = 2'h1,
    IET_HIGH = 2'h2
  } iet_speed_t;

  localparam logic [7:0]  FS_INT_MIN     = 8'h01;
  localparam logic [7:0]  LS_INT_MIN     = 8'h0a;
  localparam logic [7:0]  HS_INT_MIN     = 8'h01;
  localparam logic [7:0]  HS_INT_MAX     = 8'h10;
  localparam logic [11:0] HS_MAX_UFRAME  = 12'hc00;
  localparam logic [11:0] HS_MAX_TXN     = 12'h400;
  localparam logic [11:0] HS_TWO_TXN     = 12'h800;
  localparam logic [11:0] DEF_MAX_PKT    = 12'h040;
  localparam logic [11:0] FS_MAX_PKT     = 12'h040;
  localparam logic [11:0] LS_MAX_PKT     = 12'h008;
  localparam logic [11:0] REPLAY_BYTES   = 12'h040;
  localparam logic        PID_DATA0      = 1'b0;
  localparam int          FIFO_DEPTH     = 16;
  localparam int          FIFO_W         = 9;

  // high-speed budgeting figures
  localparam int HS_RATE_MBPS    = 480;
  localparam int IPG_BITS        = 8;
  localparam int TURN_BITS       = 88;
  localparam int SYNC_BITS       = 32;
  localparam int EOP_BITS        = 8;
  localparam int PID_BITS        = 8;
  localparam int ADDR_CRC_BITS   = 16;
  localparam int CRC16_BITS      = 16;
  localparam int HS_TXN_OVH_BITS = 3 * SYNC_BITS + 3 * PID_BITS + ADDR_CRC_BITS + CRC16_BITS
                                 + 3 * (EOP_BITS + TURN_BITS);
  localparam int UFRAME_BITS     = HS_RATE_MBPS * UFRAME_US;
  localparam int PERIODIC_PCT    = 80;
  localparam int HS_BUDGET_BITS  = UFRAME_BITS * PERIODIC_PCT / 100;
endpackage : iet_pkg

/* test/iet_checker.sv */
// Purpose: link checks between host and endpoint
// Assumes: one clock, async active-high reset
// Notes:   watches the interface signals only
`timescale 1ns/1ps
module iet_checker (
  input  wire logic       clock_i,   // clock
  input  wire logic       rst_i,     // async reset
  input  wire logic       tok_in,    // token pulse
  input  wire logic       hs_ack,    // ack pulse
  input  wire logic       clr_halt,  // halt clear pulse
  input  wire logic       nak,       // nak pulse
  input  wire logic       stall,     // stall pulse
  input  wire logic       dat_valid, // byte strobe
  input  wire logic       dat_end,   // packet end
  input  wire logic       dat_pid,   // data pid level
  input  wire logic [7:0] dat_byte   // byte value
);
  logic clr_seen_reg;
  logic clr_seen_next;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // set by a halt clear, dropped by the next token
  assign clr_seen_next = clr_halt | (clr_seen_reg & ~tok_in);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) clr_seen_reg <= 1'b0;
    else clr_seen_reg <= clr_seen_next;
  end

  ////////////////////////////////////////
  a_nak_after_token: assert property (nak |-> $past(tok_in) && !dat_valid && !dat_end)
    else $error("nak not tied to a token");
  a_stall_after_token: assert property (stall |-> $past(tok_in) && !nak)
    else $error("stall not tied to a token");
  a_data_follows: assert property (tok_in ##1 (!nak && !stall && !dat_end) |=> dat_valid)
    else $error("no data after an unrefused token");
  a_zero_len_answer: assert property (dat_end && !dat_valid |-> $past(tok_in))
    else $error("empty packet not answering a token");
  a_ack_after_end: assert property (dat_end |=> hs_ack)
    else $error("host did not ack a packet");
  a_token_when_idle: assert property (tok_in |-> !dat_valid)
    else $error("token during a packet");
  a_pid_steady: assert property (dat_valid && !dat_end |=> $stable(dat_pid))
    else $error("pid changed inside a packet");
  a_clear_data0: assert property (clr_seen_reg && tok_in ##1 (!nak && !stall) |-> !dat_pid)
    else $error("first packet after clear not data0");

  c_nak: cover property (nak);
  c_stall: cover property (stall);
  c_zero_len: cover property (dat_end && !dat_valid);
  c_ack: cover property (hs_ack);
  c_last_byte: cover property (dat_valid && dat_end && dat_byte != 8'h00);
endmodule : iet_checker

/* test/interrupt_endpoint_transfer_test.sv */
// Purpose: host and endpoint joined back to back
// Assumes: full-speed endpoint, short frame for sim
// Notes:   second endpoint only checks descriptors
`timescale 1ns/1ps
module interrupt_endpoint_transfer_test;
  import iet_pkg::*;
  logic        clock_i;
  logic        rst_i;
  logic        wr_valid;
  logic [7:0]  wr_data;
  logic        wr_last;
  logic        wr_ready;
  logic        zlp_req;
  logic        halt;
  logic        alt_sel;
  logic [7:0]  d_interval;
  logic [11:0] d_mps;
  logic        d_tog;
  logic        d_halted;
  logic        req;
  logic [15:0] req_len;
  logic        clr;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        done;
  logic        retired;
  logic        h_halted;
  logic [7:0]  x_interval;
  logic [11:0] x_mps;
  logic        x_hibw;
  logic [1:0]  h_speed;
  logic [31:0] h_budget;
  logic        h_over;
  logic        d_sent;
  logic        d_hibw;
  int          sent_cnt = 0;
  logic [7:0]  rxq[$];
  logic        pidq[$];
  int          fails = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          done_cnt = 0;
  int          ret_cnt = 0;
  int          nak_cnt = 0;
  int          stall_cnt = 0;
  int          tok_cnt = 0;

  iet_if lnk_if ();
  iet_if hs_if ();

  // second endpoint hears the same host strobes
  assign hs_if.tok_in   = lnk_if.tok_in;
  assign hs_if.hs_ack   = lnk_if.hs_ack;
  assign hs_if.clr_halt = lnk_if.clr_halt;

  iet_dev #(.SPEED(IET_FULL), .INTERVAL_REQ(8'h02), .MPS_REQ(12'h008), .TOG_ALWAYS(1'b0)) u_iet_dev (
    .clock_i(clock_i), .rst_i(rst_i), .lnk(lnk_if), .wr_valid_i(wr_valid), .wr_data_i(wr_data),
    .wr_last_i(wr_last), .wr_ready_o(wr_ready), .zlp_req_i(zlp_req), .halt_i(halt),
    .alt_setting_i(alt_sel), .interval_o(d_interval), .max_pkt_o(d_mps), .hi_bw_o(d_hibw),
    .toggle_o(d_tog), .halted_o(d_halted), .sent_o(d_sent));

  iet_dev #(.SPEED(IET_HIGH), .INTERVAL_REQ(8'h05), .MPS_REQ(12'hc00), .TOG_ALWAYS(1'b1)) u_iet_dev_hs (
    .clock_i(clock_i), .rst_i(rst_i), .lnk(hs_if), .wr_valid_i(wr_valid), .wr_data_i(wr_data),
    .wr_last_i(wr_last), .wr_ready_o(), .zlp_req_i(zlp_req), .halt_i(halt),
    .alt_setting_i(alt_sel), .interval_o(x_interval), .max_pkt_o(x_mps), .hi_bw_o(x_hibw),
    .toggle_o(), .halted_o(), .sent_o());

  iet_host #(.FRAME_CYC(100)) u_iet_host (
    .clock_i(clock_i), .rst_i(rst_i), .lnk(lnk_if), .req_i(req), .req_len_i(req_len),
    .speed_i(h_speed), .interval_i(d_interval), .mps_i(d_mps), .clear_halt_i(clr),
    .rx_valid_o(rx_valid), .rx_data_o(rx_data), .done_o(done), .retired_o(retired),
    .halted_o(h_halted), .budget_o(h_budget), .over_o(h_over));

  iet_checker u_iet_checker (
    .clock_i(clock_i), .rst_i(rst_i), .tok_in(lnk_if.tok_in), .hs_ack(lnk_if.hs_ack),
    .clr_halt(lnk_if.clr_halt), .nak(lnk_if.nak), .stall(lnk_if.stall), .dat_valid(lnk_if.dat_valid),
    .dat_end(lnk_if.dat_end), .dat_pid(lnk_if.dat_pid), .dat_byte(lnk_if.dat_byte));

  ////////////////////////////////////////
  task automatic wrap_up();
    if (fails == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : tick

  task automatic request(input logic [15:0] len);
    req = 1'b1;
    req_len = len;
    tick(1);
    req = 1'b0;
  endtask : request

  // valid held high across bytes, dropped once at the end
  task automatic send(input int n, input logic [7:0] base, input logic l);
    for (int i = 0; i < n; i++) begin
      wr_valid = 1'b1;
      wr_data = base + 8'(i);
      wr_last = l && (i == n - 1);
      do @(posedge clock_i); while (wr_ready !== 1'b1);
      #1;
    end
    wr_valid = 1'b0;
    wr_last = 1'b0;
  endtask : send

  task automatic wait_done(input int n);
    for (int i = 0; i < 1500 && done_cnt < n; i++) tick(1);
    chk(done_cnt, n);
  endtask : wait_done

  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    cyc++;
    if (rx_valid === 1'b1) rxq.push_back(rx_data);
    if (lnk_if.dat_end === 1'b1) pidq.push_back(lnk_if.dat_pid);
    if (done === 1'b1) done_cnt++;
    if (retired === 1'b1) ret_cnt++;
    if (lnk_if.nak === 1'b1) nak_cnt++;
    if (lnk_if.stall === 1'b1) stall_cnt++;
    if (lnk_if.tok_in === 1'b1) tok_cnt++;
    if (d_sent === 1'b1) sent_cnt++;
    if (cyc == 20000) begin
      fails++;
      wrap_up();
    end
  end

  ////////////////////////////////////////
  initial begin
    rst_i = 1'b1;
    {wr_valid, wr_last, zlp_req, halt, alt_sel, req, clr} = 7'h00;
    wr_data = 8'h00;
    req_len = 16'h0000;
    h_speed = IET_FULL;
    tick(20);
    rst_i = 1'b0;
    tick(2);
    chk(d_interval, 8'h02);
    chk(x_interval, 8'h05);
    chk(x_mps, 12'h040);
    chk(x_hibw, 1'b0);
    alt_sel = 1'b1;
    tick(2);
    chk(x_interval, 8'h01);
    chk(x_mps, 12'hc00);
    chk(x_hibw, 1'b1);
    tick(450);
    chk(tok_cnt, 0);
    request(16'h0006);
    tick(450);
    chk(tok_cnt > 1, 1'b1);
    chk(nak_cnt > 0, 1'b1);
    chk(done_cnt, 0);
    send(6, 8'h10, 1'b1);
    wait_done(1);
    chk(rxq.size(), 6);
    for (int i = 0; i < 6; i++) chk(rxq[i], 8'h10 + 8'(i));
    chk(pidq[0], 1'b0);
    chk(d_tog, 1'b1);
    request(16'h0008);
    send(8, 8'h20, 1'b0);
    wait_done(2);
    chk(rxq.size(), 14);
    chk(pidq[1], 1'b1);
    request(16'h0008);
    zlp_req = 1'b1;
    tick(1);
    zlp_req = 1'b0;
    wait_done(3);
    chk(rxq.size(), 14);
    chk(pidq[2], 1'b0);
    halt = 1'b1;
    request(16'h0004);
    tick(450);
    chk(stall_cnt > 0, 1'b1);
    chk(h_halted, 1'b1);
    chk(ret_cnt > 0, 1'b1);
    chk(d_halted, 1'b1);
    halt = 1'b0;
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    tick(3);
    chk(h_halted, 1'b0);
    chk(d_halted, 1'b0);
    chk(d_tog, 1'b0);
    request(16'h0004);
    send(2, 8'h30, 1'b1);
    wait_done(4);
    chk(pidq[3], 1'b0);
    chk(sent_cnt, 4);
    chk(d_hibw, 1'b0);
    h_speed = IET_HIGH;
    tick(2);
    chk(h_budget, 32'(HS_TXN_OVH_BITS) + 32'h40);
    chk(h_over, 1'b0);
    wrap_up();
  end
endmodule : interrupt_endpoint_transfer_test
